// ==== rtl/abu_pkg.sv ====
// package of constants and types for the address breakpoint unit
// assumes a core-clock IOP register port and same-clock monitored buses
//
// Summary of operation
// - control register is 32-bit read/write.
// - user enable bit 25 gates everything.
// - valid hit raises breakpoint interrupt.
// - status records which source hit.
// - return from interrupt clears all status.
// - normal match: selected access within range.
// - pm invert bit 10 matches outside range.
// - invert bits 11,12,13 for dm1,dm2,instr.
// - io mode bits 7-6 off/write/read/any.
// - group enables bits 19,20,21.
// - bit 24 selects OR or AND combining.
package abu_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          NUM_SRC       = 5;
  // register byte offsets
  localparam logic [7:0]  OFS_CONTROL   = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_START0    = 8'h10; // start of source i at +8*i
  localparam logic [7:0]  OFS_END0      = 8'h14; // end of source i at +8*i
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_MASK  = 32'h033B_FCFF; // reserved bits read zero
  // control field positions
  localparam int          POS_PM_MODE   = 0;
  localparam int          POS_DM1_MODE  = 2;
  localparam int          POS_DM2_MODE  = 4;
  localparam int          POS_IO_MODE   = 6;
  localparam int          POS_PM_INV    = 10;
  localparam int          POS_DM1_INV   = 11;
  localparam int          POS_DM2_INV   = 12;
  localparam int          POS_IA_INV    = 13;
  localparam int          POS_IO_INV    = 17;
  localparam int          POS_PM_EN     = 19;
  localparam int          POS_DM_EN     = 20;
  localparam int          POS_IA_EN     = 21;
  localparam int          POS_AND       = 24;
  localparam int          POS_USER_EN   = 25;
  // emulation status positions
  localparam int          STAT_PM       = 0;
  localparam int          STAT_DM1      = 1;
  localparam int          STAT_DM2      = 2;
  localparam int          STAT_IA       = 3;
  localparam int          STAT_IO       = 7;
  // trigger mode codes
  typedef enum logic [1:0] {
    ABU_MODE_OFF   = 2'h0,
    ABU_MODE_WRITE = 2'h1,
    ABU_MODE_READ  = 2'h2,
    ABU_MODE_ANY   = 2'h3
  } abu_mode_t;
  // source indices
  localparam int          SRC_PM        = 0;
  localparam int          SRC_DM1       = 1;
  localparam int          SRC_DM2       = 2;
  localparam int          SRC_IA        = 3;
  localparam int          SRC_IO        = 4;
endpackage : abu_pkg

// ==== rtl/abu_top.sv ====
// address breakpoint unit: range compare on pm, dm, instruction and io dma
// assumes all bus inputs come from core logic on CLK; register port is single-cycle
`timescale 1ns/1ns
`default_nettype none
module abu_top #(
  parameter int AW = 32
) (
  input  wire logic                       CLK,
  input  wire logic                       RSTN,
  input  wire logic                       CE,
  input  wire logic                       IOP_WR,
  input  wire logic                       IOP_RD,
  input  wire logic [abu_pkg::ADDR_W-1:0] IOP_ADDR,
  input  wire logic [31:0]                IOP_WDATA,
  output var  logic [31:0]                IOP_RDATA,
  input  wire logic                       PM_VALID,
  input  wire logic                       PM_WRITE,
  input  wire logic [AW-1:0]              PM_ADDR,
  input  wire logic                       DM_VALID,
  input  wire logic                       DM_WRITE,
  input  wire logic [AW-1:0]              DM_ADDR,
  input  wire logic                       IA_VALID,
  input  wire logic [AW-1:0]              IA_ADDR,
  input  wire logic                       IO_VALID,
  input  wire logic                       IO_WRITE,
  input  wire logic [AW-1:0]              IO_ADDR,
  input  wire logic                       RETURN_FROM_INTERRUPT,
  output var  logic                       HARDWARE_BREAKPOINT_INTERRUPT,
  output var  logic [7:0]                 EMULATION_STATUS
);
  import abu_pkg::*;

  logic [31:0]         breakpoint_control;
  logic [AW-1:0]       start_addr [NUM_SRC];
  logic [AW-1:0]       end_addr   [NUM_SRC];
  logic [NUM_SRC-1:0]  src_active;
  logic [NUM_SRC-1:0]  src_hit;
  logic                eff_hit;
  logic                user_breakpoint_enable;
  logic                combine_with_and;
  logic [7:0]          next_status;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // access type filter for a two-bit trigger code
  function automatic logic mode_match(input logic [1:0] mode, input logic valid,
                                      input logic write);
    logic r;
    r = 1'b0;
    case (abu_mode_t'(mode))
      ABU_MODE_OFF:   r = 1'b0;
      ABU_MODE_WRITE: r = valid & write;
      ABU_MODE_READ:  r = valid & ~write;
      ABU_MODE_ANY:   r = valid;
      default:        r = 1'b0;
    endcase
    return r;
  endfunction : mode_match

  // inclusive window, or its complement when inverted
  function automatic logic range_match(input logic [AW-1:0] a, input logic [AW-1:0] lo,
                                       input logic [AW-1:0] hi, input logic inv);
    logic r;
    r = (a >= lo) && (a <= hi);
    return inv ? ((a > hi) || (a < lo)) : r;
  endfunction : range_match

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  // control register, reserved bits never stored
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      breakpoint_control <= CONTROL_RESET;
    else if (CE && IOP_WR && IOP_ADDR == OFS_CONTROL)
      breakpoint_control <= IOP_WDATA & CONTROL_MASK;
  end

  // start and end bounds, one pair per source
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      for (int i = 0; i < NUM_SRC; i++)
      begin
        start_addr[i] <= '0;
        end_addr[i]   <= '0;
      end
    end
    else if (CE && IOP_WR)
    begin
      for (int i = 0; i < NUM_SRC; i++)
      begin
        if (IOP_ADDR == OFS_START0 + 8'(8 * i))
          start_addr[i] <= IOP_WDATA[AW-1:0];
        if (IOP_ADDR == OFS_END0 + 8'(8 * i))
          end_addr[i] <= IOP_WDATA[AW-1:0];
      end
    end
  end

  // read data, one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      IOP_RDATA <= 32'h0000_0000;
    else if (CE && IOP_RD)
    begin
      IOP_RDATA <= 32'h0000_0000;
      if (IOP_ADDR == OFS_CONTROL)
        IOP_RDATA <= breakpoint_control;
      if (IOP_ADDR == OFS_STATUS)
        IOP_RDATA <= {24'h00_0000, EMULATION_STATUS};
      for (int i = 0; i < NUM_SRC; i++)
      begin
        if (IOP_ADDR == OFS_START0 + 8'(8 * i))
          IOP_RDATA <= 32'(start_addr[i]);
        if (IOP_ADDR == OFS_END0 + 8'(8 * i))
          IOP_RDATA <= 32'(end_addr[i]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // match logic

  assign user_breakpoint_enable = breakpoint_control[POS_USER_EN];
  assign combine_with_and       = breakpoint_control[POS_AND];

  // which sources take part: group enable plus a non-zero trigger code; instr needs only its group enable, io only its code
  always_comb
  begin
    src_active[SRC_PM]  = breakpoint_control[POS_PM_EN] &&
                          breakpoint_control[POS_PM_MODE+:2] != ABU_MODE_OFF;
    src_active[SRC_DM1] = breakpoint_control[POS_DM_EN] &&
                          breakpoint_control[POS_DM1_MODE+:2] != ABU_MODE_OFF;
    src_active[SRC_DM2] = breakpoint_control[POS_DM_EN] &&
                          breakpoint_control[POS_DM2_MODE+:2] != ABU_MODE_OFF;
    src_active[SRC_IA]  = breakpoint_control[POS_IA_EN];
    src_active[SRC_IO]  = breakpoint_control[POS_IO_MODE+:2] != ABU_MODE_OFF;
  end

  // per-source hit: access type filter and range compare
  always_comb
  begin
    src_hit[SRC_PM]  = src_active[SRC_PM] &&
      mode_match(breakpoint_control[POS_PM_MODE+:2], PM_VALID, PM_WRITE) &&
      range_match(PM_ADDR, start_addr[SRC_PM], end_addr[SRC_PM],
                  breakpoint_control[POS_PM_INV]);
    src_hit[SRC_DM1] = src_active[SRC_DM1] &&
      mode_match(breakpoint_control[POS_DM1_MODE+:2], DM_VALID, DM_WRITE) &&
      range_match(DM_ADDR, start_addr[SRC_DM1], end_addr[SRC_DM1],
                  breakpoint_control[POS_DM1_INV]);
    src_hit[SRC_DM2] = src_active[SRC_DM2] &&
      mode_match(breakpoint_control[POS_DM2_MODE+:2], DM_VALID, DM_WRITE) &&
      range_match(DM_ADDR, start_addr[SRC_DM2], end_addr[SRC_DM2],
                  breakpoint_control[POS_DM2_INV]);
    // instruction fetches carry no direction, so any fetch qualifies
    src_hit[SRC_IA]  = src_active[SRC_IA] && IA_VALID &&
      range_match(IA_ADDR, start_addr[SRC_IA], end_addr[SRC_IA],
                  breakpoint_control[POS_IA_INV]);
    src_hit[SRC_IO]  = src_active[SRC_IO] &&
      mode_match(breakpoint_control[POS_IO_MODE+:2], IO_VALID, IO_WRITE) &&
      range_match(IO_ADDR, start_addr[SRC_IO], end_addr[SRC_IO],
                  breakpoint_control[POS_IO_INV]);
  end

  // effective breakpoint; AND needs every taking-part source in one cycle
  always_comb
  begin
    if (combine_with_and)
      eff_hit = (src_active != '0) && ((src_hit | ~src_active) == '1);
    else
      eff_hit = (src_hit != '0);
    eff_hit = eff_hit && user_breakpoint_enable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and status

  // one-cycle request to the sequencer per effective hit
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      HARDWARE_BREAKPOINT_INTERRUPT <= 1'b0;
    else if (CE)
      HARDWARE_BREAKPOINT_INTERRUPT <= eff_hit;
  end

  // sticky status; a hit in the clearing cycle survives the clear
  always_comb
  begin
    next_status = RETURN_FROM_INTERRUPT ? 8'h00 : EMULATION_STATUS;
    if (eff_hit)
    begin
      next_status[STAT_PM]  = next_status[STAT_PM]  | src_hit[SRC_PM];
      next_status[STAT_DM1] = next_status[STAT_DM1] | src_hit[SRC_DM1];
      next_status[STAT_DM2] = next_status[STAT_DM2] | src_hit[SRC_DM2];
      next_status[STAT_IA]  = next_status[STAT_IA]  | src_hit[SRC_IA];
      next_status[STAT_IO]  = next_status[STAT_IO]  | src_hit[SRC_IO];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      EMULATION_STATUS <= 8'h00;
    else if (CE)
      EMULATION_STATUS <= next_status;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_ctrl_store;
    @(posedge CLK) disable iff (!RSTN)
      (CE && IOP_WR && IOP_ADDR == OFS_CONTROL) |=>
        breakpoint_control == ($past(IOP_WDATA) & CONTROL_MASK);
  endproperty
  a_ctrl_store: assert property (p_ctrl_store) else $error("control write lost");

  property p_user_gate;
    @(posedge CLK) disable iff (!RSTN)
      (CE && !breakpoint_control[POS_USER_EN]) |=> !HARDWARE_BREAKPOINT_INTERRUPT;
  endproperty
  a_user_gate: assert property (p_user_gate) else $error("irq while user off");

  property p_irq_follows;
    @(posedge CLK) disable iff (!RSTN)
      (CE && eff_hit) |=> HARDWARE_BREAKPOINT_INTERRUPT ##1 (!CE || !$past(eff_hit) ||
                                                              HARDWARE_BREAKPOINT_INTERRUPT);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("hit gave no irq");

  property p_status_pm;
    @(posedge CLK) disable iff (!RSTN)
      (CE && eff_hit && src_hit[SRC_PM]) |=>
        EMULATION_STATUS[STAT_PM] && HARDWARE_BREAKPOINT_INTERRUPT;
  endproperty
  a_status_pm: assert property (p_status_pm) else $error("pm status not set");

  property p_rti_clear;
    @(posedge CLK) disable iff (!RSTN)
      (CE && RETURN_FROM_INTERRUPT && !eff_hit) |=> EMULATION_STATUS == 8'h00;
  endproperty
  a_rti_clear: assert property (p_rti_clear) else $error("status not cleared");

  property p_pm_inside;
    @(posedge CLK) disable iff (!RSTN)
      (src_active[SRC_PM] && !breakpoint_control[POS_PM_INV] && PM_VALID &&
       breakpoint_control[POS_PM_MODE+:2] == ABU_MODE_ANY &&
       PM_ADDR >= start_addr[SRC_PM] && PM_ADDR <= end_addr[SRC_PM]) |-> src_hit[SRC_PM];
  endproperty
  a_pm_inside: assert property (p_pm_inside) else $error("in-range pm missed");

  property p_pm_invert;
    @(posedge CLK) disable iff (!RSTN)
      (breakpoint_control[POS_PM_INV] && PM_ADDR >= start_addr[SRC_PM] &&
       PM_ADDR <= end_addr[SRC_PM]) |-> !src_hit[SRC_PM];
  endproperty
  a_pm_invert: assert property (p_pm_invert) else $error("inverted pm hit inside");

  property p_dm1_invert;
    @(posedge CLK) disable iff (!RSTN)
      (src_active[SRC_DM1] && breakpoint_control[POS_DM1_INV] && DM_VALID &&
       breakpoint_control[POS_DM1_MODE+:2] == ABU_MODE_ANY &&
       DM_ADDR > end_addr[SRC_DM1]) |-> src_hit[SRC_DM1];
  endproperty
  a_dm1_invert: assert property (p_dm1_invert) else $error("inverted dm1 missed");

  property p_io_write_only;
    @(posedge CLK) disable iff (!RSTN)
      (breakpoint_control[POS_IO_MODE+:2] == ABU_MODE_WRITE && !IO_WRITE) |->
        !src_hit[SRC_IO];
  endproperty
  a_io_write_only: assert property (p_io_write_only) else $error("io read hit");

  property p_dm_group_off;
    @(posedge CLK) disable iff (!RSTN)
      (!breakpoint_control[POS_DM_EN] || breakpoint_control[POS_DM1_MODE+:2] == 2'h0)
        |-> !src_hit[SRC_DM1];
  endproperty
  a_dm_group_off: assert property (p_dm_group_off) else $error("dm1 hit disabled");

  property p_group_gate;
    @(posedge CLK) disable iff (!RSTN)
      !breakpoint_control[POS_DM_EN] |-> !src_hit[SRC_DM1] && !src_hit[SRC_DM2];
  endproperty
  a_group_gate: assert property (p_group_gate) else $error("dm group ignored");

  property p_and_combine;
    @(posedge CLK) disable iff (!RSTN)
      (combine_with_and && src_active[SRC_PM] && !src_hit[SRC_PM]) |-> !eff_hit;
  endproperty
  a_and_combine: assert property (p_and_combine) else $error("and mode misfired");

endmodule : abu_top
`default_nettype wire

// ==== testbench/abu_core_model.sv ====
// core bus model: drives pm, dm, instruction and io dma accesses
// assumes the bench calls access() between clock edges of CLK
`timescale 1ns/1ns
`default_nettype none
module abu_core_model #(
  parameter int AW = 16
) (
  input  wire logic          CLK,
  output var  logic          PM_VALID,
  output var  logic          PM_WRITE,
  output var  logic [AW-1:0] PM_ADDR,
  output var  logic          DM_VALID,
  output var  logic          DM_WRITE,
  output var  logic [AW-1:0] DM_ADDR,
  output var  logic          IA_VALID,
  output var  logic [AW-1:0] IA_ADDR,
  output var  logic          IO_VALID,
  output var  logic          IO_WRITE,
  output var  logic [AW-1:0] IO_ADDR
);
  ////////////////////////////////////////////////////////////////
  // buses idle with no valid
  initial
  begin
    {PM_VALID, DM_VALID, IA_VALID, IO_VALID} = 4'h0;
    {PM_WRITE, DM_WRITE, IO_WRITE} = 3'h0;
    {PM_ADDR, DM_ADDR, IA_ADDR, IO_ADDR} = '0;
  end
  ////////////////////////////////////////////////////////////////
  // one-cycle access on the buses in bus (0 pm, 1 dm, 2 instr, 3 io)
  task automatic access(input logic [3:0] bus, input logic wr, input logic [AW-1:0] a);
    @(posedge CLK);
    {IO_VALID, IA_VALID, DM_VALID, PM_VALID} <= bus;
    {PM_WRITE, DM_WRITE, IO_WRITE} <= {3{wr}};
    {PM_ADDR, DM_ADDR, IA_ADDR, IO_ADDR} <= {4{a}};
    @(posedge CLK);
    {IO_VALID, IA_VALID, DM_VALID, PM_VALID} <= 4'h0;
    // released address is not held: show its inverse
    {PM_ADDR, DM_ADDR, IA_ADDR, IO_ADDR} <= {4{~a}};
    #1;
  endtask : access
endmodule : abu_core_model
`default_nettype wire

// ==== testbench/address_breakpoint_unit_test.sv ====
// self-checking bench for the address breakpoint unit
// assumes abu_pkg and abu_top compiled first; core model drives the buses
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module address_breakpoint_unit_test;
  import abu_pkg::*;
  logic        CLK, RSTN, CE, IOP_WR, IOP_RD, RETURN_FROM_INTERRUPT;
  logic [7:0]  IOP_ADDR, EMULATION_STATUS;
  logic [31:0] IOP_WDATA, IOP_RDATA, rd;
  logic        PM_VALID, PM_WRITE, DM_VALID, DM_WRITE, IA_VALID, IO_VALID, IO_WRITE;
  logic [15:0] PM_ADDR, DM_ADDR, IA_ADDR, IO_ADDR;
  logic        HARDWARE_BREAKPOINT_INTERRUPT;
  int          n_fail, n_compared;
  // per-source field positions; io has no group enable, so user enable stands in
  int          mpos [5] = '{POS_PM_MODE, POS_DM1_MODE, POS_DM2_MODE, 0, POS_IO_MODE};
  int          ipos [5] = '{POS_PM_INV, POS_DM1_INV, POS_DM2_INV, POS_IA_INV, POS_IO_INV};
  int          epos [5] = '{POS_PM_EN, POS_DM_EN, POS_DM_EN, POS_IA_EN, POS_USER_EN};
  int          sbit [5] = '{STAT_PM, STAT_DM1, STAT_DM2, STAT_IA, STAT_IO};
  logic [3:0]  busof [5] = '{4'h1, 4'h2, 4'h2, 4'h4, 4'h8};
  logic [15:0] probe_a [4] = '{16'h00FF, 16'h0100, 16'h01FF, 16'h0200};
  ////////////////////////////////////////////////////////////////
  abu_top #(.AW(16)) dut (.CLK(CLK), .RSTN(RSTN), .CE(CE), .IOP_WR(IOP_WR),
    .IOP_RD(IOP_RD), .IOP_ADDR(IOP_ADDR), .IOP_WDATA(IOP_WDATA), .IOP_RDATA(IOP_RDATA),
    .PM_VALID(PM_VALID), .PM_WRITE(PM_WRITE), .PM_ADDR(PM_ADDR), .DM_VALID(DM_VALID),
    .DM_WRITE(DM_WRITE), .DM_ADDR(DM_ADDR), .IA_VALID(IA_VALID), .IA_ADDR(IA_ADDR),
    .IO_VALID(IO_VALID), .IO_WRITE(IO_WRITE), .IO_ADDR(IO_ADDR),
    .RETURN_FROM_INTERRUPT(RETURN_FROM_INTERRUPT),
    .HARDWARE_BREAKPOINT_INTERRUPT(HARDWARE_BREAKPOINT_INTERRUPT),
    .EMULATION_STATUS(EMULATION_STATUS));
  abu_core_model #(.AW(16)) core (.CLK(CLK), .PM_VALID(PM_VALID), .PM_WRITE(PM_WRITE),
    .PM_ADDR(PM_ADDR), .DM_VALID(DM_VALID), .DM_WRITE(DM_WRITE), .DM_ADDR(DM_ADDR),
    .IA_VALID(IA_VALID), .IA_ADDR(IA_ADDR), .IO_VALID(IO_VALID), .IO_WRITE(IO_WRITE),
    .IO_ADDR(IO_ADDR));
  ////////////////////////////////////////////////////////////////
  // register port cycles; two spare cycles after a write before any access
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    IOP_WR <= 1'b1;
    IOP_ADDR <= a;
    IOP_WDATA <= d;
    @(posedge CLK);
    IOP_WR <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    IOP_RD <= 1'b1;
    IOP_ADDR <= a;
    @(posedge CLK);
    IOP_RD <= 1'b0;
    #1;
    d = IOP_RDATA;
  endtask : reg_rd
  // control word for one source; instruction source has no mode field
  function automatic logic [31:0] ctl(input int s, input logic [1:0] m, input logic inv,
                                      input logic en);
    logic [31:0] c;
    c = '0;
    c[POS_USER_EN] = 1'b1;
    if (s != SRC_IA) c[mpos[s] +: 2] = m;
    c[ipos[s]] = inv;
    c[epos[s]] = en;
    return c;
  endfunction : ctl
  // one access, judge interrupt and status, then return from interrupt
  task automatic probe(input logic [3:0] bus, input logic wr, input logic [15:0] a,
                       input logic e_irq, input logic [7:0] e_st);
    core.access(bus, wr, a);
    `CHK("interrupt", e_irq, HARDWARE_BREAKPOINT_INTERRUPT)
    `CHK("status", e_st, EMULATION_STATUS)
    @(posedge CLK);
    RETURN_FROM_INTERRUPT <= 1'b1;
    #1;
    `CHK("interrupt drop", 1'b0, HARDWARE_BREAKPOINT_INTERRUPT)
    @(posedge CLK);
    RETURN_FROM_INTERRUPT <= 1'b0;
    #1;
    `CHK("status clear", 8'h00, EMULATION_STATUS)
  endtask : probe
  ////////////////////////////////////////////////////////////////
  // reset values, mask of reserved bits, read-only status, unmapped place
  task automatic t_regs;
    reg_rd(OFS_CONTROL, rd);
    `CHK("control reset", CONTROL_RESET, rd)
    reg_wr(OFS_CONTROL, 32'hFFFF_FFFF);
    reg_rd(OFS_CONTROL, rd);
    `CHK("control mask", CONTROL_MASK, rd)
    reg_wr(OFS_STATUS, 32'h0000_00FF);
    reg_rd(OFS_STATUS, rd);
    `CHK("status ro", 32'h0000_0000, rd)
    reg_rd(8'h08, rd);
    `CHK("unmapped", 32'h0000_0000, rd)
    for (int i = 0; i < 5; i++)
    begin
      reg_wr(OFS_START0 + 8'(8 * i), 32'h0000_0100);
      reg_wr(OFS_END0 + 8'(8 * i), 32'h0000_01FF);
    end
  endtask : t_regs
  // every trigger code against reads and writes, with user enable, plus one pm write without it
  task automatic t_modes;
    logic e;
    reg_wr(OFS_CONTROL, ctl(SRC_PM, 2'h3, 1'b0, 1'b1) & ~32'h0200_0000);
    probe(4'h1, 1'b1, 16'h0150, 1'b0, 8'h00);
    for (int s = 0; s < 5; s++)
      for (int m = 0; m < 4; m++)
        for (int w = 0; w < 2; w++)
        begin
          if (s == SRC_IA) continue;
          e = (m == 3) || (m == 1 && w == 1) || (m == 2 && w == 0);
          reg_wr(OFS_CONTROL, ctl(s, 2'(m), 1'b0, 1'b1));
          probe(busof[s], 1'(w), 16'h0150, e, e ? 8'(1 << sbit[s]) : 8'h00);
        end
  endtask : t_modes
  // both bounds and their neighbours, normal and inverted, every source
  task automatic t_ranges;
    logic e;
    for (int s = 0; s < 5; s++)
      for (int v = 0; v < 2; v++)
        for (int k = 0; k < 4; k++)
        begin
          e = 1'(v) ^ (k == 1 || k == 2);
          reg_wr(OFS_CONTROL, ctl(s, 2'h3, 1'(v), 1'b1));
          probe(busof[s], 1'b0, probe_a[k], e, e ? 8'(1 << sbit[s]) : 8'h00);
        end
  endtask : t_ranges
  // group enables off, then or and and combining
  task automatic t_combine;
    for (int s = 0; s < 4; s++)
    begin
      reg_wr(OFS_CONTROL, ctl(s, 2'h3, 1'b0, 1'b0));
      probe(busof[s], 1'b0, 16'h0150, 1'b0, 8'h00);
    end
    reg_wr(OFS_CONTROL, ctl(SRC_PM, 2'h3, 1'b0, 1'b1) | ctl(SRC_DM1, 2'h3, 1'b0, 1'b1));
    probe(4'h1, 1'b0, 16'h0150, 1'b1, 8'h01);
    probe(4'h3, 1'b0, 16'h0150, 1'b1, 8'h03);
    reg_wr(OFS_CONTROL, ctl(SRC_PM, 2'h3, 1'b0, 1'b1) | ctl(SRC_DM1, 2'h3, 1'b0, 1'b1)
                        | 32'h0100_0000);
    probe(4'h1, 1'b0, 16'h0150, 1'b0, 8'h00);
    probe(4'h3, 1'b0, 16'h0150, 1'b1, 8'h03);
  endtask : t_combine
  // clock enable low ignores register strobes and hits; status reads back on the port
  task automatic t_freeze;
    reg_wr(OFS_CONTROL, ctl(SRC_PM, 2'h3, 1'b0, 1'b1));
    CE <= 1'b0;
    reg_wr(OFS_CONTROL, 32'h0000_0000);
    probe(4'h1, 1'b0, 16'h0150, 1'b0, 8'h00);
    @(posedge CLK);
    CE <= 1'b1;
    reg_rd(OFS_CONTROL, rd);
    `CHK("frozen control", ctl(SRC_PM, 2'h3, 1'b0, 1'b1), rd)
    core.access(4'h1, 1'b0, 16'h0150);
    reg_rd(OFS_STATUS, rd);
    `CHK("status read", 32'h0000_0001, rd)
    probe(4'h1, 1'b0, 16'h0000, 1'b0, 8'h01);
  endtask : t_freeze
  ////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  // clock, reset and main sequence
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial
  begin
    {RSTN, IOP_WR, IOP_RD, RETURN_FROM_INTERRUPT} = 4'h0;
    CE = 1'b1;
    {IOP_ADDR, IOP_WDATA, n_fail, n_compared} = '0;
    repeat (3) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    t_regs();
    t_modes();
    t_ranges();
    t_combine();
    t_freeze();
    conclude();
  end
  // watchdog well beyond the roughly 720 cycles the run needs
  initial
  begin
    repeat (20000) @(posedge CLK);
    n_fail++;
    conclude();
  end
endmodule : address_breakpoint_unit_test
`default_nettype wire
